//--- include/jie_pkg.sv
/*
  constants, commands and states for the serial test-port programming block.
  assumes one 20 MHz clock and a slow test clock sampled as an ordinary input.
*/
// Operation
// - while secured, no memory read-out through any path.
// - while secured, only full-chip erase runs; program, erase, verify blocked.
// - finished full-chip erase leaves the part unsecured and blank.
// - every sector has a protect bit; protected sectors refuse erasure; full-chip erase still clears them.
// - test pins sit on port c bits 0,1,3,4,5,6 as mode, clock, status, error, in, out.
// - delivered state: every memory bit reads one.
// - delivered state: every configuration bit is zero.
// - enable register bit 0: zero disables port, one enables it.
// - with pins dedicated by nonvolatile bit, device reset leaves operations alone.
// - with port enabled only by register, device reset aborts and blocks operations.
// - test pins active when dedicate bit, enable bit or select term holds; status and error pins also need CMD_ENABLE.
// - device reset clears the enable bit; software may clear it too.
// - error pin low on failed erase or program until cleared.
// - status pin low while program or erase runs, high when readable.
package jie_pkg;
  // -------------------------------------------------------------
  // sizes and timing
  // -------------------------------------------------------------
  localparam int SECTORS = 12;
  localparam int FRAME_BITS = 16;
  localparam int CLK_NS = 50;
  localparam int OP_TIME_NS = 2000;
  localparam logic [7:0] OP_CYCLES = 8'((OP_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam int ENABLE_BIT = 0;
  // -------------------------------------------------------------
  // serial commands, frame = {command, address, data}
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_ENABLE = 4'h1, CMD_DISABLE = 4'h2, CMD_CLEAR = 4'h3, CMD_READ = 4'h4,
    CMD_PROGRAM = 4'h5, CMD_VERIFY = 4'h6, CMD_SECTOR_ERASE = 4'h7, CMD_CHIP_ERASE = 4'h8
  } jie_cmd_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001, S_BUSY = 3'b010, S_HALT = 3'b100
  } jie_state_e;
endpackage : jie_pkg

//--- rtl/jie_test_port.sv
/*
  serial test-port programming channel with security, sector protection and
  a small flash array. assumes pins arrive unsynchronised; nonvolatile bits and
  the select term come from logic on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module jie_test_port
  import jie_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_reset_n,
  input wire logic nvm_dedicate,
  input wire logic nvm_security,
  input wire logic [SECTORS-1:0] sector_protect,
  input wire logic test_pin_select_term,
  input wire logic mcu_wr,
  input wire logic [7:0] mcu_wdata,
  output logic [7:0] mcu_rdata,
  input wire logic port_c_bit_zero,
  input wire logic port_c_bit_one,
  input wire logic port_c_bit_five,
  output logic port_c_bit_six,
  output logic port_c_bit_six_oe,
  output logic port_c_bit_three,
  output logic port_c_bit_three_oe,
  output logic port_c_bit_four,
  output logic port_c_bit_four_oe
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [3:0] pin_s1, pin_s2;
  logic tck_q, tms_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1 <= 4'h8;
      pin_s2 <= 4'h8;
      tck_q <= 1'b0;
      tms_q <= 1'b0;
    end
    else
    begin
      pin_s1 <= {dev_reset_n, port_c_bit_five, port_c_bit_one, port_c_bit_zero};
      pin_s2 <= pin_s1;
      tck_q <= pin_s2[1];
      tms_q <= pin_s2[0];
    end
  end
  wire logic tms_s = pin_s2[0];
  wire logic tdi_s = pin_s2[2];
  wire logic dev_rst_act = ~pin_s2[3];
  wire logic tck_rise = pin_s2[1] & ~tck_q;
  wire logic frame_end = tms_q & ~tms_s;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  jie_state_e state, next_state;
  logic [7:0] enable_reg, next_enable_reg;
  logic secure, next_secure, sec_loaded, next_sec_loaded;
  logic ext_on, next_ext_on, err, next_err;
  logic [FRAME_BITS-1:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] busy_cnt, next_busy_cnt;
  jie_cmd_e op, next_op;
  logic [3:0] op_addr, next_op_addr;
  logic [7:0] op_data, next_op_data;
  logic [7:0] mem [SECTORS];
  logic [7:0] next_mem [SECTORS];
  logic port_on, rst_block, exec_go, bad_addr;
  jie_cmd_e cmd;
  logic [3:0] addr;
  logic [7:0] data, cur;

  always_comb
  begin
    port_on = nvm_dedicate | enable_reg[ENABLE_BIT] | test_pin_select_term;
    rst_block = dev_rst_act & ~nvm_dedicate;
    cmd = jie_cmd_e'(shift_in[15:12]);
    addr = shift_in[11:8];
    data = shift_in[7:0];
    bad_addr = (addr >= 4'(SECTORS));
    cur = bad_addr ? BLANK_BYTE : mem[addr];
    exec_go = port_on & ~rst_block & frame_end & (bit_cnt == 5'(FRAME_BITS)) & (state == S_IDLE);
    next_state = state;
    next_enable_reg = enable_reg;
    next_secure = secure;
    next_sec_loaded = 1'b1;
    next_ext_on = ext_on;
    next_err = err;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt = bit_cnt;
    next_busy_cnt = busy_cnt;
    next_op = op;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_mem = mem;
    if (!sec_loaded)
      next_secure = nvm_security;
    if (mcu_wr)
      next_enable_reg = {7'h00, mcu_wdata[ENABLE_BIT]};
    if (dev_rst_act)
      next_enable_reg = ENABLE_RESET;
    // error cleared by clear command, or by device reset once extensions are off
    if (exec_go && cmd == CMD_CLEAR)
      next_err = 1'b0;
    if (dev_rst_act && !ext_on)
      next_err = 1'b0;
    // serial frame capture
    if (!port_on || rst_block)
    begin
      next_bit_cnt = 5'h00;
      next_shift_in = '0;
    end
    else if (frame_end)
      next_bit_cnt = 5'h00;
    else if (tms_s && tck_rise)
    begin
      next_shift_in = {shift_in[FRAME_BITS-2:0], tdi_s};
      next_shift_out = {shift_out[6:0], 1'b0};
      if (bit_cnt != 5'(FRAME_BITS))
        next_bit_cnt = bit_cnt + 5'h01;
    end
    // command execution
    case (state)
      S_IDLE:
      begin
        if (rst_block)
          next_state = S_HALT;
        else if (exec_go)
        begin
          next_op = cmd;
          next_op_addr = addr;
          next_op_data = data;
          case (cmd)
            CMD_ENABLE: next_ext_on = 1'b1;
            CMD_DISABLE: next_ext_on = 1'b0;
            CMD_READ: next_shift_out = secure ? 8'h00 : cur;
            CMD_VERIFY:
              if (!secure && (bad_addr || cur != data))
                next_err = 1'b1;
            CMD_PROGRAM, CMD_SECTOR_ERASE, CMD_CHIP_ERASE:
              if (cmd == CMD_CHIP_ERASE || !secure)
              begin
                if (cmd == CMD_PROGRAM && (bad_addr || ((~cur & data) != 8'h00)))
                  next_err = 1'b1;
                else if (cmd == CMD_SECTOR_ERASE && (bad_addr || sector_protect[addr]))
                  next_err = 1'b1;
                else
                begin
                  next_state = S_BUSY;
                  next_busy_cnt = OP_CYCLES;
                end
              end
            default: next_op = op;
          endcase
        end
      end
      S_BUSY:
      begin
        if (rst_block)
          next_state = S_HALT;
        else if (busy_cnt > 8'h01)
          next_busy_cnt = busy_cnt - 8'h01;
        else
        begin
          next_state = S_IDLE;
          next_busy_cnt = 8'h00;
          if (op == CMD_PROGRAM)
            next_mem[op_addr] = mem[op_addr] & op_data;
          else if (op == CMD_SECTOR_ERASE)
            next_mem[op_addr] = BLANK_BYTE;
          else
          begin
            for (int i = 0; i < SECTORS; i++)
              next_mem[i] = BLANK_BYTE;
            next_secure = 1'b0;
          end
        end
      end
      S_HALT:
        if (!rst_block)
          next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_IDLE;
      enable_reg <= ENABLE_RESET;
      secure <= 1'b0;
      sec_loaded <= 1'b0;
      ext_on <= 1'b0;
      err <= 1'b0;
      shift_in <= '0;
      shift_out <= 8'h00;
      bit_cnt <= 5'h00;
      busy_cnt <= 8'h00;
      op <= CMD_ENABLE;
      op_addr <= 4'h0;
      op_data <= 8'h00;
      for (int i = 0; i < SECTORS; i++)
        mem[i] <= BLANK_BYTE;
    end
    else
    begin
      state <= next_state;
      enable_reg <= next_enable_reg;
      secure <= next_secure;
      sec_loaded <= next_sec_loaded;
      ext_on <= next_ext_on;
      err <= next_err;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt <= next_bit_cnt;
      busy_cnt <= next_busy_cnt;
      op <= next_op;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      mem <= next_mem;
    end
  end

  // -------------------------------------------------------------
  // registered pin and register outputs
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mcu_rdata <= 8'h00;
      port_c_bit_six <= 1'b0;
      port_c_bit_six_oe <= 1'b0;
      port_c_bit_three <= 1'b1;
      port_c_bit_three_oe <= 1'b0;
      port_c_bit_four <= 1'b1;
      port_c_bit_four_oe <= 1'b0;
    end
    else
    begin
      mcu_rdata <= enable_reg;
      port_c_bit_six <= shift_out[7];
      port_c_bit_six_oe <= port_on;
      port_c_bit_three <= (state != S_BUSY);
      port_c_bit_three_oe <= port_on & ext_on;
      port_c_bit_four <= ~err;
      port_c_bit_four_oe <= port_on & ext_on;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_chip_last;
    state == S_BUSY && op == CMD_CHIP_ERASE && busy_cnt == 8'h01 && !rst_block;
  endsequence
  sequence s_blank_open;
    !secure && mem[0] == BLANK_BYTE && mem[SECTORS-1] == BLANK_BYTE;
  endsequence
  a_read_secured: assert property (exec_go && cmd == CMD_READ && secure |=> shift_out == 8'h00)
    else $error("read data leaked while secured");
  a_cmd_blocked: assert property (exec_go && secure && cmd != CMD_CHIP_ERASE |=> state != S_BUSY)
    else $error("command ran while secured");
  a_chip_blank: assert property (s_chip_last |=> s_blank_open)
    else $error("chip erase did not leave part blank and open");
  a_secure_held: assert property ($fell(secure) && $past(sec_loaded) |-> $past(state == S_BUSY))
    else $error("security dropped outside chip erase");
  a_protect_erase: assert property (exec_go && cmd == CMD_SECTOR_ERASE && !secure && !bad_addr
    && sector_protect[addr] |=> state == S_IDLE && err)
    else $error("protected sector erase accepted");
  a_enable_write: assert property (mcu_wr && !dev_rst_act |=> enable_reg[0] == $past(mcu_wdata[0]))
    else $error("enable bit not written");
  a_reset_clear: assert property (dev_rst_act |=> enable_reg == 8'h00 ##1 mcu_rdata == 8'h00)
    else $error("device reset did not clear enable");
  a_reset_abort: assert property (rst_block && state == S_BUSY |=> state == S_HALT)
    else $error("busy cycle not aborted by reset");
  a_dedicated_run: assert property (nvm_dedicate && state == S_BUSY && busy_cnt > 8'h01 |=> state == S_BUSY)
    else $error("dedicated port disturbed by reset");
  a_error_pin: assert property (err |=> !port_c_bit_four)
    else $error("error pin not low");
  a_status_pin: assert property (state == S_BUSY |=> !port_c_bit_three)
    else $error("status pin not low while busy");
  a_status_ready: assert property (state != S_BUSY |=> port_c_bit_three)
    else $error("status pin not high while readable");
  a_tdo_enable: assert property (port_on |=> port_c_bit_six_oe)
    else $error("output pin not enabled");
endmodule : jie_test_port
`default_nettype wire

//--- test/jie_prog_model.sv
/*
  serial programming controller model: drives mode, test clock and data in.
  assumes the test clock is slow (400 ns) and unrelated to the device clock.
*/
`timescale 1ns/100ps
`default_nettype none
module jie_prog_model (
  output logic mode_sel,
  output logic test_clk,
  output logic data_in,
  input wire logic data_out
);
  initial
  begin
    mode_sel = 1'b0;
    test_clk = 1'b0;
    data_in = 1'b0;
  end
  // one 16-bit frame msb first; returns the byte shifted out on rises 1 to 8
  task automatic frame(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    mode_sel = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      data_in = f[i];
      #200;
      if (i > 7)
        rd = {rd[6:0], data_out};
      test_clk = 1'b1;
      #200 test_clk = 1'b0;
    end
    mode_sel = 1'b0;
    data_in = ~data_in;
  endtask : frame
endmodule : jie_prog_model
`default_nettype wire

//--- test/jie_test_port_test.sv
/*
  self-checking bench for the test-port block with the programmer model.
  assumes the design's own assertions run inside it.
*/
`timescale 1ns/100ps
`default_nettype none
module jie_test_port_test;
  import jie_pkg::*;
  logic clk, nrst, dev_reset_n, nvm_dedicate, nvm_security, test_pin_select_term, mcu_wr;
  logic [SECTORS-1:0] sector_protect;
  logic [7:0] mcu_wdata, mcu_rdata, a_rd, d, r;
  logic [3:0] a;
  logic tms, tck, tdi, tdo, tdo_oe, stat, stat_oe, err, err_oe;
  int n_errors, tests_run, cycles, seed;
  jie_test_port DUT (.clk(clk), .nrst(nrst), .dev_reset_n(dev_reset_n), .nvm_dedicate(nvm_dedicate),
    .nvm_security(nvm_security), .sector_protect(sector_protect), .test_pin_select_term(test_pin_select_term),
    .mcu_wr(mcu_wr), .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata), .port_c_bit_zero(tms),
    .port_c_bit_one(tck), .port_c_bit_five(tdi), .port_c_bit_six(tdo), .port_c_bit_six_oe(tdo_oe),
    .port_c_bit_three(stat), .port_c_bit_three_oe(stat_oe), .port_c_bit_four(err), .port_c_bit_four_oe(err_oe));
  jie_prog_model PM (.mode_sel(tms), .test_clk(tck), .data_in(tdi), .data_out(tdo));
  always #25 clk = ~clk;
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset();
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic wr_en(input logic [7:0] v);
    @(posedge clk);
    #1 mcu_wr = 1'b1;
    mcu_wdata = v;
    @(posedge clk);
    #1 mcu_wr = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("enable reg", v & 8'h01, mcu_rdata);
  endtask : wr_en
  // e: expected status 12 cycles after the frame, or -1 to skip
  task automatic cmd(input jie_cmd_e c, input logic [3:0] ad, input logic [7:0] dt, input int e);
    int n;
    PM.frame({c, ad, dt}, a_rd);
    repeat (12) @(posedge clk);
    #1;
    if (e >= 0)
      chk("status pin", 8'(e), {7'h0, stat});
    n = 0;
    while (stat !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("status idle", 8'h01, {7'h0, stat});
  endtask : cmd
  task automatic rd_byte(input logic [3:0] ad, input logic [7:0] exp);
    cmd(CMD_READ, ad, 8'h00, -1);
    cmd(CMD_ENABLE, 4'h0, 8'h00, 1);
    chk("read byte", exp, a_rd);
  endtask : rd_byte
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    dev_reset_n = 1'b1;
    nvm_dedicate = 1'b0;
    nvm_security = 1'b0;
    test_pin_select_term = 1'b0;
    mcu_wr = 1'b0;
    mcu_wdata = 8'h00;
    sector_protect = '0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    seed = 32'hbaa4;
    a = 4'(($random(seed) & 32'h7fff) % SECTORS);
    d = 8'($random(seed)) & 8'hfe;
    do_reset();
    chk("enable reg", ENABLE_RESET, mcu_rdata);
    chk("out oe", 8'h00, {7'h0, tdo_oe});
    wr_en(8'h01);
    chk("out oe", 8'h01, {7'h0, tdo_oe});
    wr_en(8'h00);
    chk("out oe", 8'h00, {7'h0, tdo_oe});
    wr_en(8'h01);
    cmd(CMD_ENABLE, 4'h0, 8'h00, 1);
    chk("status oe", 8'h01, {7'h0, stat_oe});
    chk("error oe", 8'h01, {7'h0, err_oe});
    rd_byte(a, BLANK_BYTE);
    cmd(CMD_PROGRAM, a, d, 0);
    rd_byte(a, d);
    cmd(CMD_PROGRAM, a, 8'hff, -1);
    chk("error pin", 8'h00, {7'h0, err});
    cmd(CMD_CLEAR, 4'h0, 8'h00, 1);
    chk("error pin", 8'h01, {7'h0, err});
    sector_protect[a] = 1'b1;
    cmd(CMD_SECTOR_ERASE, a, 8'h00, -1);
    chk("error pin", 8'h00, {7'h0, err});
    rd_byte(a, d);
    sector_protect[a] = 1'b0;
    cmd(CMD_CLEAR, 4'h0, 8'h00, 1);
    cmd(CMD_SECTOR_ERASE, a, 8'h00, 0);
    rd_byte(a, BLANK_BYTE);
    nvm_security = 1'b1;
    do_reset();
    wr_en(8'h01);
    cmd(CMD_ENABLE, 4'h0, 8'h00, 1);
    rd_byte(a, 8'h00);
    cmd(CMD_PROGRAM, a, d, 1);
    cmd(CMD_VERIFY, a, d, 1);
    chk("error pin", 8'h01, {7'h0, err});
    cmd(CMD_CHIP_ERASE, 4'h0, 8'h00, 0);
    rd_byte(a, BLANK_BYTE);
    cmd(CMD_PROGRAM, a, d, 0);
    rd_byte(a, d);
    nvm_security = 1'b0;
    do_reset();
    wr_en(8'h01);
    PM.frame({CMD_PROGRAM, a, d}, r);
    repeat (12) @(posedge clk);
    #1 dev_reset_n = 1'b0;
    repeat (60) @(posedge clk);
    #1 chk("enable reg", 8'h00, mcu_rdata);
    dev_reset_n = 1'b1;
    repeat (4) @(posedge clk);
    wr_en(8'h01);
    rd_byte(a, BLANK_BYTE);
    nvm_dedicate = 1'b1;
    dev_reset_n = 1'b0;
    cmd(CMD_PROGRAM, a, d, 0);
    rd_byte(a, d);
    dev_reset_n = 1'b1;
    nvm_dedicate = 1'b0;
    test_pin_select_term = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("out oe", 8'h01, {7'h0, tdo_oe});
    cmd(CMD_DISABLE, 4'h0, 8'h00, 1);
    chk("status oe", 8'h00, {7'h0, stat_oe});
    chk("error oe", 8'h00, {7'h0, err_oe});
    test_pin_select_term = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("out oe", 8'h00, {7'h0, tdo_oe});
    print_verdict();
  end
endmodule : jie_test_port_test
`default_nettype wire
